// file: rtl/ebi_regs.vh
/*
 * constants for the external bus interface: pin widths, bus width codes,
 * chip select field layout, byte enable codes and state encodings.
 * assumes inclusion by bare name from the rtl files.
 */
`ifndef EBI_REGS_VH
`define EBI_REGS_VH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define EBI_ADR_W        26
`define EBI_ASI_W        4
`define EBI_NCS          6
`define EBI_WAIT_W       4
`define EBI_RANGE_W      8
`define EBI_DRAM_W       12

// ----------------------------------------------------------------------
// bus width codes
// ----------------------------------------------------------------------
`define EBI_BW_8         2'h0
`define EBI_BW_16        2'h1
`define EBI_BW_32        2'h2

// ----------------------------------------------------------------------
// transfer sizes
// ----------------------------------------------------------------------
`define EBI_SZ_BYTE      2'h0
`define EBI_SZ_HALF      2'h1
`define EBI_SZ_WORD      2'h2
`define EBI_SZ_DBL       2'h3

// ----------------------------------------------------------------------
// system support control, global select enable
// ----------------------------------------------------------------------
`define EBI_SSC_CSEN     4

// ----------------------------------------------------------------------
// active-low byte enable codes, lane 0 in bit 3
// ----------------------------------------------------------------------
`define EBI_BE_B0        4'h7
`define EBI_BE_B1        4'hb
`define EBI_BE_B2        4'hd
`define EBI_BE_B3        4'he
`define EBI_BE_H0        4'h3
`define EBI_BE_H1        4'hc
`define EBI_BE_ALL       4'h0
`define EBI_BE_NONE      4'hf

// ----------------------------------------------------------------------
// sequencer states and reset values
// ----------------------------------------------------------------------
`define EBI_ST_IDLE      2'h0
`define EBI_ST_STRB      2'h1
`define EBI_ST_WAIT      2'h2
`define EBI_ADR_RST      26'h0000000
`define EBI_WAIT_ZERO    4'h0

`endif

// file: rtl/ebi_csdec.v
/*
 * chip select decoder: one comparator per range select against its
 * base and mask, combinational. assumes the caller qualifies with the
 * strobe and registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ebi_regs.vh"

module ebi_csdec (
  input  wire [`EBI_ADR_W-1:0]            adr_in,
  input  wire [`EBI_ASI_W-1:0]            asi_in,
  input  wire [5*`EBI_RANGE_W-1:0]        base_in,
  input  wire [5*`EBI_RANGE_W-1:0]        mask_in,
  input  wire                             csen_in,
  output reg  [`EBI_NCS-1:0]              hit_out
);

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  // upper 4 address bits count as zero, so the compared key is the top
  // address bits with the space identifier below them
  wire [`EBI_RANGE_W-1:0] key = {adr_in[`EBI_ADR_W-1:`EBI_ADR_W-4], asi_in};
  integer i;

  always @* begin
    hit_out = {`EBI_NCS{1'b0}};
    // boot select has no range and ignores the global enable
    hit_out[0] = ~(|hit_out[`EBI_NCS-1:1]); // R12
    for (i = 1; i < `EBI_NCS; i = i + 1) begin
      hit_out[i] = csen_in &
        (((key ^ base_in[(i-1)*`EBI_RANGE_W +: `EBI_RANGE_W]) &
          ~mask_in[(i-1)*`EBI_RANGE_W +: `EBI_RANGE_W]) ==
         {`EBI_RANGE_W{1'b0}}); // R11
    end
    hit_out[0] = ~(|hit_out[`EBI_NCS-1:1]); // R12
  end

endmodule // ebi_csdec
`default_nettype wire

// file: rtl/ebi_waitgen.v
/*
 * wait-state counter: loads a count when a cycle starts and pulses ready
 * once the count has run out. assumes one start pulse per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ebi_regs.vh"

module ebi_waitgen (
  input  wire                    clk_in,
  input  wire                    rst_n_in,
  input  wire                    start_in,
  input  wire [`EBI_WAIT_W-1:0]  waits_in,
  output reg                     ready_out
);

  reg [`EBI_WAIT_W-1:0] cnt_q;
  reg                   busy_q;

  // -------------------------------------------------------------------
  // count
  // -------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q     <= `EBI_WAIT_ZERO;
      busy_q    <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      ready_out <= 1'b0;
      if (start_in) begin
        cnt_q  <= waits_in;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == `EBI_WAIT_ZERO) begin
          busy_q    <= 1'b0;
          ready_out <= 1'b1; // R13
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule // ebi_waitgen
`default_nettype wire

// file: rtl/ebi_top.v
/*
 * external bus interface signalling: starts bus cycles for the core,
 * drives word address, space identifier, strobe, byte enables, data and
 * chip selects, and generates ready after programmed waits. in bus
 * grant the pins turn to inputs and an external master's strobe starts
 * the select and wait logic. assumes all inputs synchronous to MCLK_IN.
 */
// How it works
// R01: strobe low one clock at cycle start
// R02: cycle runs from strobe until any ready
// R03: word address on address bits 27..2
// R04: narrow bus puts low address on lanes
// R05: others ignore address when idle
// R06: grant: address input, top bits zero
// R07: dram enabled muxes row/column on 13..2
// R08: space identifier timed like address
// R09: grant: identifier input, upper bits zero
// R10: grant: external strobe triggers selects, waits
// R11: range selects need hit and global enable
// R12: boot select always enabled
// R13: ready generated after programmed clock count
// R14: transfers aligned to their size
// R15: narrow bus uses low data lines only
// R16: write enables mark bytes; reads all
// R17: others sample enables only in cycle
// R18: grant: enables float, 16-bit lane2 input
// R19: write enable codes per size, offset
`timescale 1ns/1ps
`default_nettype none
`include "ebi_regs.vh"

module ebi_top (
  input  wire                       MCLK_IN,
  input  wire                       RST_N_IN,
  // core request side
  input  wire                       REQ_IN,
  input  wire                       REQ_WRITE_IN,
  input  wire [1:0]                 REQ_SIZE_IN,
  input  wire [27:0]                REQ_ADDR_IN,
  input  wire [`EBI_ASI_W-1:0]      REQ_ASI_IN,
  input  wire [31:0]                REQ_WDATA_IN,
  output reg                        REQ_BUSY_OUT,
  output reg                        REQ_DONE_OUT,
  output reg                        REQ_ALIGN_ERR_OUT,
  output reg  [31:0]                REQ_RDATA_OUT,
  // configuration
  input  wire [1:0]                 BUS_WIDTH_IN,
  input  wire [7:0]                 SYSTEM_SUPPORT_CONTROL_IN,
  input  wire [5*`EBI_RANGE_W-1:0]  RANGE_BASE_REGISTER_IN,
  input  wire [5*`EBI_RANGE_W-1:0]  RANGE_MASK_REGISTER_IN,
  input  wire [6*`EBI_WAIT_W-1:0]   WAIT_COUNTS_IN,
  input  wire                       BUS_GRANT_IN,
  input  wire                       DRAM_EN_IN,
  input  wire                       DRAM_COL_PHASE_IN,
  // pins
  input  wire [`EBI_ADR_W-1:0]      ADR_IN,
  output reg  [`EBI_ADR_W-1:0]      ADR_OUT,
  output reg                        ADR_OE_N_OUT,
  input  wire [`EBI_ASI_W-1:0]      SPACE_IDENTIFIER_LINES_IN,
  output reg  [`EBI_ASI_W-1:0]      SPACE_IDENTIFIER_LINES_OUT,
  input  wire                       ADDRESS_STROBE_N_IN,
  output reg                        ADDRESS_STROBE_N_OUT,
  output reg                        ADDRESS_STROBE_OE_N_OUT,
  input  wire [3:0]                 BYTE_LANE_ENABLES_N_IN,
  output reg  [3:0]                 BYTE_LANE_ENABLES_N_OUT,
  output reg                        BYTE_LANE_OE_N_OUT,
  input  wire [31:0]                DATA_IN,
  output reg  [31:0]                DATA_OUT,
  output reg  [3:0]                 DATA_OE_N_OUT,
  input  wire                       READY_N_IN,
  output reg                        GENERATED_READY_OUT,
  output reg                        BOOT_SELECT_N_OUT,
  output reg  [`EBI_NCS-2:0]        RANGE_SELECT_N_OUT,
  output reg                        GRANT_ADR1_OUT
);

  // -------------------------------------------------------------------
  // functions
  // -------------------------------------------------------------------
  function misaligned;
    input [1:0] size;
    input [2:0] a;
    begin
      case (size)
        `EBI_SZ_BYTE: misaligned = 1'b0;
        `EBI_SZ_HALF: misaligned = a[0];
        `EBI_SZ_WORD: misaligned = |a[1:0];
        default:      misaligned = |a[2:0];
      endcase
    end
  endfunction

  // active-low enables for a write on a full-width bus
  function [3:0] wr_enables;
    input [1:0] size;
    input [1:0] a;
    begin
      case (size)
        `EBI_SZ_BYTE:
          case (a)
            2'h0:    wr_enables = `EBI_BE_B0;
            2'h1:    wr_enables = `EBI_BE_B1;
            2'h2:    wr_enables = `EBI_BE_B2;
            default: wr_enables = `EBI_BE_B3;
          endcase
        `EBI_SZ_HALF:
          wr_enables = a[1] ? `EBI_BE_H1 : `EBI_BE_H0;
        default: wr_enables = `EBI_BE_ALL;
      endcase
    end
  endfunction

  // pin vector carries lane 0 in bit 0; the code above has lane 0 in
  // bit 3, so flip it on the way out
  function [3:0] flip4;
    input [3:0] v;
    begin
      flip4 = {v[0], v[1], v[2], v[3]};
    end
  endfunction

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  reg [1:0]             st_q;
  reg [1:0]             st_d;
  reg [`EBI_WAIT_W-1:0] waits_sel;
  reg [`EBI_NCS-1:0]    cs_q;
  wire [`EBI_NCS-1:0]   cs_hit;
  wire                  gen_rdy;
  integer               k;

  wire [`EBI_ADR_W-1:0] dec_adr = BUS_GRANT_IN ? ADR_IN
                                  : REQ_ADDR_IN[27:2]; // R06
  wire [`EBI_ASI_W-1:0] dec_asi = BUS_GRANT_IN ? SPACE_IDENTIFIER_LINES_IN
                                  : REQ_ASI_IN; // R09
  wire own_start = !BUS_GRANT_IN && st_q == `EBI_ST_IDLE && REQ_IN &&
                   !misaligned(REQ_SIZE_IN, REQ_ADDR_IN[2:0]); // R14
  wire ext_start = BUS_GRANT_IN && !ADDRESS_STROBE_N_IN; // R10
  wire start     = own_start | ext_start;
  wire any_rdy   = !READY_N_IN | gen_rdy; // R02

  ebi_csdec u_csdec (
    .adr_in  (dec_adr),
    .asi_in  (dec_asi),
    .base_in (RANGE_BASE_REGISTER_IN),
    .mask_in (RANGE_MASK_REGISTER_IN),
    .csen_in (SYSTEM_SUPPORT_CONTROL_IN[`EBI_SSC_CSEN]),
    .hit_out (cs_hit)
  );

  always @* begin
    waits_sel = `EBI_WAIT_ZERO;
    for (k = 0; k < `EBI_NCS; k = k + 1) begin
      if (cs_hit[k])
        waits_sel = WAIT_COUNTS_IN[k*`EBI_WAIT_W +: `EBI_WAIT_W];
    end
  end

  ebi_waitgen u_wait (
    .clk_in    (MCLK_IN),
    .rst_n_in  (RST_N_IN),
    .start_in  (start),
    .waits_in  (waits_sel),
    .ready_out (gen_rdy)
  );

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  always @* begin
    st_d = st_q;
    case (st_q)
      `EBI_ST_IDLE: begin
        if (own_start)
          st_d = `EBI_ST_STRB;
      end
      `EBI_ST_STRB: begin
        st_d = any_rdy ? `EBI_ST_IDLE : `EBI_ST_WAIT;
      end
      `EBI_ST_WAIT: begin
        if (any_rdy)
          st_d = `EBI_ST_IDLE; // R02
      end
      default: st_d = `EBI_ST_IDLE;
    endcase
  end

  // -------------------------------------------------------------------
  // pin and status registers
  // -------------------------------------------------------------------
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q                       <= `EBI_ST_IDLE;
      cs_q                       <= {`EBI_NCS{1'b0}};
      REQ_BUSY_OUT               <= 1'b0;
      REQ_DONE_OUT               <= 1'b0;
      REQ_ALIGN_ERR_OUT          <= 1'b0;
      REQ_RDATA_OUT              <= 32'h00000000;
      ADR_OUT                    <= `EBI_ADR_RST;
      ADR_OE_N_OUT               <= 1'b1;
      SPACE_IDENTIFIER_LINES_OUT <= {`EBI_ASI_W{1'b0}};
      ADDRESS_STROBE_N_OUT       <= 1'b1;
      ADDRESS_STROBE_OE_N_OUT    <= 1'b1;
      BYTE_LANE_ENABLES_N_OUT    <= `EBI_BE_NONE;
      BYTE_LANE_OE_N_OUT         <= 1'b1;
      DATA_OUT                   <= 32'h00000000;
      DATA_OE_N_OUT              <= 4'hf;
      GENERATED_READY_OUT        <= 1'b0;
      BOOT_SELECT_N_OUT          <= 1'b1;
      RANGE_SELECT_N_OUT         <= {(`EBI_NCS-1){1'b1}};
      GRANT_ADR1_OUT             <= 1'b0;
    end else begin
      st_q                 <= st_d;
      REQ_DONE_OUT         <= 1'b0;
      REQ_ALIGN_ERR_OUT    <= !BUS_GRANT_IN && st_q == `EBI_ST_IDLE &&
                              REQ_IN &&
                              misaligned(REQ_SIZE_IN, REQ_ADDR_IN[2:0]);
      ADDRESS_STROBE_N_OUT <= !own_start; // R01
      GENERATED_READY_OUT  <= gen_rdy; // R13
      // in grant the pins are inputs; the address, strobe and byte lane enables stay high
      ADR_OE_N_OUT            <= BUS_GRANT_IN; // R06
      ADDRESS_STROBE_OE_N_OUT <= BUS_GRANT_IN; // R10
      BYTE_LANE_OE_N_OUT      <= BUS_GRANT_IN; // R18
      // lane 2 carries address bit 1 at its true level, as when driven
      GRANT_ADR1_OUT <= BUS_GRANT_IN && BUS_WIDTH_IN == `EBI_BW_16 &&
                        BYTE_LANE_ENABLES_N_IN[2]; // R18
      if (start) begin
        cs_q    <= cs_hit; // R11
      end else if (any_rdy) begin
        cs_q    <= {`EBI_NCS{1'b0}};
      end
      BOOT_SELECT_N_OUT  <= !(start ? cs_hit[0] : (cs_q[0] && !any_rdy));
      RANGE_SELECT_N_OUT <= ~(start ? cs_hit[`EBI_NCS-1:1]
                             : (cs_q[`EBI_NCS-1:1] &
                                {(`EBI_NCS-1){!any_rdy}}));
      if (st_d != `EBI_ST_IDLE)
        REQ_BUSY_OUT <= 1'b1;
      else
        REQ_BUSY_OUT <= 1'b0;
      if (own_start) begin
        // dram multiplexing replaces the low word address bits
        ADR_OUT <= REQ_ADDR_IN[27:2]; // R03
        if (DRAM_EN_IN && DRAM_COL_PHASE_IN)
          ADR_OUT[`EBI_DRAM_W-1:0] <=
            {REQ_ADDR_IN[27:26], REQ_ADDR_IN[25:16]}; // R07
        SPACE_IDENTIFIER_LINES_OUT <= REQ_ASI_IN; // R08
        if (REQ_WRITE_IN && BUS_WIDTH_IN == `EBI_BW_32)
          BYTE_LANE_ENABLES_N_OUT <=
            flip4(wr_enables(REQ_SIZE_IN, REQ_ADDR_IN[1:0])); // R19
        else
          BYTE_LANE_ENABLES_N_OUT <= `EBI_BE_ALL; // R16
        if (BUS_WIDTH_IN == `EBI_BW_8) begin
          BYTE_LANE_ENABLES_N_OUT[2] <= REQ_ADDR_IN[1]; // R04
          BYTE_LANE_ENABLES_N_OUT[3] <= REQ_ADDR_IN[0]; // R04
        end else if (BUS_WIDTH_IN == `EBI_BW_16) begin
          BYTE_LANE_ENABLES_N_OUT[2] <= REQ_ADDR_IN[1]; // R04
        end
        DATA_OUT <= REQ_WDATA_IN;
        if (REQ_WRITE_IN) begin
          case (BUS_WIDTH_IN)
            `EBI_BW_8:  DATA_OE_N_OUT <= 4'he; // R15
            `EBI_BW_16: DATA_OE_N_OUT <= 4'hc; // R15
            default:    DATA_OE_N_OUT <= 4'h0;
          endcase
        end else begin
          DATA_OE_N_OUT <= 4'hf;
        end
      end else if (st_q != `EBI_ST_IDLE && any_rdy) begin
        REQ_DONE_OUT <= 1'b1;
        DATA_OE_N_OUT <= 4'hf;
        case (BUS_WIDTH_IN)
          `EBI_BW_8:  REQ_RDATA_OUT <= {24'h000000, DATA_IN[7:0]}; // R15
          `EBI_BW_16: REQ_RDATA_OUT <= {16'h0000, DATA_IN[15:0]}; // R15
          default:    REQ_RDATA_OUT <= DATA_IN;
        endcase
      end
    end
  end

endmodule // ebi_top
`default_nettype wire

// file: tb/ebi_asserts.sv
/*
 * pin-level checker for ebi_top, bound to every instance of it.
 * assumes one clock, MCLK_IN, and the asynchronous low reset RST_N_IN.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ebi_regs.vh"
module ebi_asserts (
  input wire logic        MCLK_IN,
  input wire logic        RST_N_IN,
  input wire logic [27:0] REQ_ADDR_IN,
  input wire logic [3:0]  REQ_ASI_IN,
  input wire logic        REQ_BUSY_OUT,
  input wire logic        REQ_DONE_OUT,
  input wire logic        REQ_ALIGN_ERR_OUT,
  input wire logic [1:0]  BUS_WIDTH_IN,
  input wire logic [7:0]  SYSTEM_SUPPORT_CONTROL_IN,
  input wire logic        BUS_GRANT_IN,
  input wire logic        DRAM_EN_IN,
  input wire logic        DRAM_COL_PHASE_IN,
  input wire logic [25:0] ADR_OUT,
  input wire logic        ADR_OE_N_OUT,
  input wire logic [3:0]  SPACE_IDENTIFIER_LINES_OUT,
  input wire logic        ADDRESS_STROBE_N_IN,
  input wire logic        ADDRESS_STROBE_N_OUT,
  input wire logic        ADDRESS_STROBE_OE_N_OUT,
  input wire logic        BYTE_LANE_OE_N_OUT,
  input wire logic [3:0]  DATA_OE_N_OUT,
  input wire logic        READY_N_IN,
  input wire logic        GENERATED_READY_OUT,
  input wire logic        BOOT_SELECT_N_OUT,
  input wire logic [4:0]  RANGE_SELECT_N_OUT
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  wire [25:0] req_word = REQ_ADDR_IN[27:2];
  wire [11:0] req_hi   = REQ_ADDR_IN[27:16];
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_strobe_one_clk: assert property ($fell(ADDRESS_STROBE_N_OUT) |=> ADDRESS_STROBE_N_OUT)
    else $error("strobe held low beyond one clock");
  a_ready_ends_cycle: assert property ($past(REQ_BUSY_OUT) && (GENERATED_READY_OUT || !READY_N_IN) |-> ##[0:2] REQ_DONE_OUT)
    else $error("cycle did not end after ready");
  a_addr_space_out: assert property (!DRAM_EN_IN && $fell(ADDRESS_STROBE_N_OUT) |-> ADR_OUT == $past(req_word) && SPACE_IDENTIFIER_LINES_OUT == $past(REQ_ASI_IN))
    else $error("address or space id wrong at strobe");
  a_dram_column: assert property (DRAM_EN_IN && DRAM_COL_PHASE_IN && $fell(ADDRESS_STROBE_N_OUT) |-> ADR_OUT[11:0] == $past(req_hi))
    else $error("column address not on low lines");
  a_global_enable: assert property (!ADDRESS_STROBE_N_OUT && !SYSTEM_SUPPORT_CONTROL_IN[`EBI_SSC_CSEN] |-> &RANGE_SELECT_N_OUT)
    else $error("range select without global enable");
  a_boot_default: assert property (!ADDRESS_STROBE_N_OUT && &RANGE_SELECT_N_OUT |-> !BOOT_SELECT_N_OUT)
    else $error("boot select missing");
  a_grant_float: assert property (BUS_GRANT_IN [*3] |-> ADR_OE_N_OUT && BYTE_LANE_OE_N_OUT && ADDRESS_STROBE_OE_N_OUT)
    else $error("pins driven during grant");
  a_grant_trigger: assert property (BUS_GRANT_IN && $fell(ADDRESS_STROBE_N_IN) |-> ##[1:20] GENERATED_READY_OUT)
    else $error("external strobe gave no ready");
  a_narrow_lanes: assert property (BUS_WIDTH_IN == `EBI_BW_8 |-> &DATA_OE_N_OUT[3:1])
    else $error("upper data lanes driven on 8-bit bus");
  a_refuse_clean: assert property (REQ_ALIGN_ERR_OUT |-> ADDRESS_STROBE_N_OUT && !REQ_BUSY_OUT)
    else $error("misaligned request started a cycle");
  c_done: cover property (REQ_DONE_OUT);
  c_align: cover property (REQ_ALIGN_ERR_OUT);
  c_grant_sel: cover property (BUS_GRANT_IN && !RANGE_SELECT_N_OUT[0]);
endmodule // ebi_asserts
bind ebi_top ebi_asserts u_chk (.*);
`default_nettype wire

// file: tb/ebi_mem_model.sv
/*
 * memory/peripheral on the far side of the bus: answers each strobe with
 * a word pattern, and with its own ready after delay_in when enabled.
 * assumes strobe and address already resolved from all drivers.
 */
`timescale 1ns/1ps
`default_nettype none
module ebi_mem_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        strobe_n_in,
  input  wire logic [25:0] adr_in,
  input  wire logic        gen_rdy_in,
  input  wire logic        ext_en_in,
  input  wire logic [3:0]  delay_in,
  output logic             ready_n_out,
  output logic [31:0]      data_out
);
  logic        busy_q;
  logic [3:0]  cnt_q;
  logic [25:0] adr_q;
  logic [31:0] junk_q;
  function automatic logic [31:0] pat(input logic [25:0] w);
    pat = {w[7:0] ^ 8'ha5, w[15:8], w[23:16], w[7:0] ^ 8'h3c};
  endfunction
  // idle bus toggles so a stale word can never pass for read data
  assign data_out = !strobe_n_in ? pat(adr_in) : busy_q ? pat(adr_q) : junk_q;
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      adr_q <= 26'h0;
      ready_n_out <= 1'b1;
      junk_q <= 32'h5a5a5a5a;
    end else begin
      junk_q <= ~junk_q;
      ready_n_out <= 1'b1;
      if (!busy_q && !strobe_n_in) begin
        busy_q <= 1'b1;
        cnt_q <= delay_in;
        adr_q <= adr_in;
      end else if (busy_q && (gen_rdy_in || !ready_n_out)) begin
        busy_q <= 1'b0;
      end else if (busy_q && ext_en_in) begin
        if (cnt_q == 4'h0) ready_n_out <= 1'b0;
        else cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // ebi_mem_model
`default_nettype wire

// file: tb/tb_top.sv
/*
 * self-checking bench for ebi_top: core requests through req, grant
 * traffic driven directly. assumes the memory model on the far side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ebi_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic MCLK_IN = 0, RST_N_IN = 0, REQ_IN = 0, REQ_WRITE_IN = 0, g_as = 1, ext_en = 0;
  logic BUS_GRANT_IN = 0, DRAM_EN_IN = 0, DRAM_COL_PHASE_IN = 0, boot, err, stb;
  logic [1:0]  REQ_SIZE_IN = 0, BUS_WIDTH_IN = `EBI_BW_32;
  logic [27:0] REQ_ADDR_IN = 0;
  logic [31:0] REQ_WDATA_IN = 0, rd;
  logic [7:0]  SYSTEM_SUPPORT_CONTROL_IN = 0;
  logic [39:0] RANGE_BASE_REGISTER_IN = 40'h0000700035, RANGE_MASK_REGISTER_IN = 40'h00000f0000;
  logic [23:0] WAIT_COUNTS_IN = 24'h111111;
  logic [25:0] g_adr = 0, ad;
  logic [3:0]  REQ_ASI_IN = 0, g_asi = 0, g_be = 4'hf, dly = 1, be, doe;
  logic [4:0]  cs;
  wire         REQ_BUSY_OUT, REQ_DONE_OUT, REQ_ALIGN_ERR_OUT, ADR_OE_N_OUT, READY_N_IN;
  wire         ADDRESS_STROBE_N_OUT, ADDRESS_STROBE_OE_N_OUT, ADDRESS_STROBE_N_IN;
  wire         BYTE_LANE_OE_N_OUT, GENERATED_READY_OUT, BOOT_SELECT_N_OUT, GRANT_ADR1_OUT;
  wire [31:0]  REQ_RDATA_OUT, DATA_OUT, DATA_IN;
  wire [25:0]  ADR_OUT, ADR_IN;
  wire [3:0]   SPACE_IDENTIFIER_LINES_OUT, SPACE_IDENTIFIER_LINES_IN, DATA_OE_N_OUT;
  wire [3:0]   BYTE_LANE_ENABLES_N_OUT, BYTE_LANE_ENABLES_N_IN;
  wire [4:0]   RANGE_SELECT_N_OUT;
  integer      miscompares = 0, total_checks = 0, gr, g1, n, i;
  // pin order: lane n in bit n, so byte 0 alone is 4'he
  logic [3:0]  bexp [7] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0};
  logic [1:0]  boff [7] = '{0, 1, 2, 3, 0, 2, 0};
  // ----------------------------------------------------------------
  // pins resolved from whichever side drives them
  // ----------------------------------------------------------------
  assign ADR_IN = ADR_OE_N_OUT ? g_adr : ADR_OUT;
  assign SPACE_IDENTIFIER_LINES_IN = ADR_OE_N_OUT ? g_asi : SPACE_IDENTIFIER_LINES_OUT;
  assign ADDRESS_STROBE_N_IN = ADDRESS_STROBE_OE_N_OUT ? g_as : ADDRESS_STROBE_N_OUT;
  assign BYTE_LANE_ENABLES_N_IN = BYTE_LANE_OE_N_OUT ? g_be : BYTE_LANE_ENABLES_N_OUT;
  ebi_top u_dut (.*);
  ebi_mem_model u_mem (.mclk_in(MCLK_IN), .rst_n_in(RST_N_IN), .strobe_n_in(ADDRESS_STROBE_N_IN),
    .adr_in(ADR_IN), .gen_rdy_in(GENERATED_READY_OUT), .ext_en_in(ext_en), .delay_in(dly),
    .ready_n_out(READY_N_IN), .data_out(DATA_IN));
  always #2.5 MCLK_IN = ~MCLK_IN;
  function automatic logic [31:0] pat(input logic [25:0] w);
    pat = {w[7:0] ^ 8'ha5, w[15:8], w[23:16], w[7:0] ^ 8'h3c};
  endfunction
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic req(input logic w, input logic [1:0] sz, input logic [27:0] a, input logic [3:0] s);
    @(negedge MCLK_IN);
    {REQ_IN, REQ_WRITE_IN, REQ_SIZE_IN, REQ_ADDR_IN, REQ_ASI_IN} = {1'b1, w, sz, a, s};
    REQ_WDATA_IN = {a, 4'h9};
    @(negedge MCLK_IN);
    REQ_IN = 0;
    // strobe and refusal pulse stand only in the cycle after the take
    {err, stb, be, cs, boot, doe, ad} = {REQ_ALIGN_ERR_OUT, ADDRESS_STROBE_N_OUT,
      BYTE_LANE_ENABLES_N_OUT, RANGE_SELECT_N_OUT, BOOT_SELECT_N_OUT, DATA_OE_N_OUT, ADR_OUT};
    gr = 0;
    n = 0;
    while (!err && REQ_DONE_OUT !== 1'b1 && n < 40) begin
      @(negedge MCLK_IN);
      n++;
      if (GENERATED_READY_OUT === 1'b1 && gr == 0) gr = n;
    end
    rd = REQ_RDATA_OUT;
    `CHK(n < 40, 1'b1)
    // stale wait counts must run out before the next cycle
    repeat (20) @(negedge MCLK_IN);
  endtask
  task automatic tdone(input string s);
    $display("end of test %0s", s);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge MCLK_IN);
    RST_N_IN = 1;
    for (i = 0; i < 7; i++) begin
      req(1, i < 4 ? `EBI_SZ_BYTE : i < 6 ? `EBI_SZ_HALF : `EBI_SZ_WORD, 28'h0123450 + boff[i], 4'h2);
      `CHK(be, bexp[i])
      `CHK(stb, 1'b0)
      `CHK(DATA_OUT, {28'h0123450 + boff[i], 4'h9})
    end
    req(0, `EBI_SZ_WORD, 28'h0abcde8, 4'h6);
    `CHK(be, 4'h0)
    `CHK(rd, pat(26'h02af37a))
    tdone("wide");
    BUS_WIDTH_IN = `EBI_BW_8;
    req(1, `EBI_SZ_BYTE, 28'h0000126, 4'h1);
    `CHK(be[3:2], 2'h1)
    `CHK(doe[3:1], 3'h7)
    req(0, `EBI_SZ_BYTE, 28'h0000124, 4'h1);
    `CHK(rd, pat(26'h49) & 32'hff)
    BUS_WIDTH_IN = `EBI_BW_16;
    req(1, `EBI_SZ_HALF, 28'h0000122, 4'h1);
    `CHK(be[2], 1'b1)
    BUS_WIDTH_IN = `EBI_BW_32;
    tdone("narrow");
    req(0, `EBI_SZ_WORD, 28'h0000040, 4'h0);
    g1 = gr;
    WAIT_COUNTS_IN[3:0] = 4'h6;
    req(0, `EBI_SZ_WORD, 28'h0000040, 4'h0);
    `CHK(gr - g1, 5)
    {ext_en, WAIT_COUNTS_IN[3:0]} = {1'b1, 4'hf};
    req(0, `EBI_SZ_WORD, 28'h0000040, 4'h0);
    `CHK(n < 6, 1'b1)
    {ext_en, WAIT_COUNTS_IN[3:0]} = {1'b0, 4'h1};
    tdone("waits");
    req(0, `EBI_SZ_WORD, 28'h3000000, 4'h5);
    `CHK({cs, boot}, 6'h3e)
    SYSTEM_SUPPORT_CONTROL_IN = 8'h10;
    req(0, `EBI_SZ_WORD, 28'h3000000, 4'h5);
    `CHK({cs, boot}, 6'h3d)
    req(0, `EBI_SZ_WORD, 28'h7000000, 4'h9);
    `CHK({cs, boot}, 6'h37)
    req(0, `EBI_SZ_WORD, 28'h8000000, 4'h5);
    `CHK({cs, boot}, 6'h3e)
    tdone("selects");
    for (i = 0; i < 3; i++) begin
      req(0, i + 1, 28'h0000100 + (i == 0 ? 1 : i * 2), 4'h0);
      `CHK({err, stb}, 2'h3)
    end
    req(0, `EBI_SZ_DBL, 28'h0000108, 4'h0);
    `CHK({err, stb}, 2'h0)
    {DRAM_EN_IN, DRAM_COL_PHASE_IN} = 2'h3;
    req(0, `EBI_SZ_WORD, 28'habc1234, 4'h0);
    `CHK(ad[11:0], 12'habc)
    {DRAM_EN_IN, DRAM_COL_PHASE_IN} = 2'h0;
    tdone("align dram");
    {BUS_GRANT_IN, g_adr, g_asi} = {1'b1, 26'h0c00000, 4'h5};
    repeat (3) @(negedge MCLK_IN);
    `CHK({ADR_OE_N_OUT, BYTE_LANE_OE_N_OUT}, 2'h3)
    g_as = 0;
    @(negedge MCLK_IN);
    g_as = 1;
    for (n = 0; n < 4 && RANGE_SELECT_N_OUT[0] !== 1'b0; n++) @(negedge MCLK_IN);
    `CHK(RANGE_SELECT_N_OUT[0], 1'b0)
    repeat (20) @(negedge MCLK_IN);
    BUS_WIDTH_IN = `EBI_BW_16;
    repeat (2) @(negedge MCLK_IN);
    `CHK(GRANT_ADR1_OUT, 1'b1)
    g_be = 4'h0;
    repeat (2) @(negedge MCLK_IN);
    `CHK(GRANT_ADR1_OUT, 1'b0)
    BUS_GRANT_IN = 0;
    tdone("grant");
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
